// ==== spsc_ctrl_model.sv ====
// Remote controller model issuing one command at a time
`default_nettype none
module spsc_ctrl_model
    import spsc_pkg::*;
(
    // Command port
    input  wire logic      sys_clk,
    output var spsc_cmd_s  cmd,
    input  wire spsc_rsp_s rsp
);
    timeunit 1ns/1ps;
    initial cmd = '0;
    task automatic send(input spsc_op_e op, input logic [15:0] arg,
                        output logic [15:0] data, output logic err);
        @(posedge sys_clk) #1 cmd = '{1'b1, op, arg};
        @(posedge sys_clk) #1 data = rsp.valid ? rsp.data : 16'hxxxx;
        err = rsp.err;
        // Released fields are scrambled so stale values cannot pass
        cmd = '{1'b0, spsc_op_e'(~op), ~arg};
    endtask
endmodule // spsc_ctrl_model
`default_nettype wire

// ==== spsc_pkg.sv ====
// Shared constants, commands and carriers of the supply protection and status block
`default_nettype none

package spsc_pkg;

    // ------------------------------------------------------------------
    // Register geometry and bit positions
    // ------------------------------------------------------------------
    localparam int           REG_W          = 16;
    localparam int           OPER_WAIT_BIT  = 5;
    localparam int           OPER_VOLT_BIT  = 8;
    localparam int           OPER_CURR_BIT  = 10;
    localparam int           QUES_VOLT_BIT  = 0;
    localparam int           QUES_CURR_BIT  = 1;
    localparam int           QUES_TEMP_BIT  = 4;
    localparam int           QUES_INHB_BIT  = 9;
    localparam int           QUES_NOREG_BIT = 10;
    localparam logic [15:0]  OPER_USED_MASK = 16'h0520;
    localparam logic [15:0]  QUES_USED_MASK = 16'h0613;
    localparam int           SB_QUES_BIT    = 3;
    localparam int           SB_OPER_BIT    = 7;

    // ------------------------------------------------------------------
    // Reset values and delay limits
    // ------------------------------------------------------------------
    localparam logic [15:0]  ENAB_RST       = 16'h0000;
    localparam logic [15:0]  FALL_RST       = 16'h0000;
    localparam logic [15:0]  RISE_RST       = 16'h0000;
    localparam logic [15:0]  DELAY_RST      = 16'h0000;
    localparam logic [15:0]  DELAY_MIN      = 16'h0000;
    localparam logic [15:0]  DELAY_MAX      = 16'hFFFF;

    // ------------------------------------------------------------------
    // Timing: one delay count is one millisecond
    // ------------------------------------------------------------------
    localparam int           CLK_HZ         = 50_000_000;
    localparam int           DELAY_LSB_US   = 1000;
    localparam int           DELAY_UNIT_CYC = CLK_HZ / 1_000_000 * DELAY_LSB_US;

    // ------------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_PROT_CLEAR   = 5'h00,
        OP_DELAY_SET    = 5'h01,
        OP_DELAY_QRY    = 5'h02,
        OP_DELAY_MIN    = 5'h03,
        OP_DELAY_MAX    = 5'h04,
        OP_RELAY_SET    = 5'h05,
        OP_RELAY_QRY    = 5'h06,
        OP_POL_SET      = 5'h07,
        OP_POL_QRY      = 5'h08,
        OP_OCP_SET      = 5'h09,
        OP_OPER_COND    = 5'h0A,
        OP_OPER_ENAB    = 5'h0B,
        OP_OPER_ENAB_Q  = 5'h0C,
        OP_OPER_EVEN    = 5'h0D,
        OP_OPER_FALL    = 5'h0E,
        OP_OPER_FALL_Q  = 5'h0F,
        OP_OPER_RISE    = 5'h10,
        OP_OPER_RISE_Q  = 5'h11,
        OP_QUES_COND    = 5'h12,
        OP_QUES_ENAB    = 5'h13,
        OP_QUES_ENAB_Q  = 5'h14,
        OP_QUES_EVEN    = 5'h15,
        OP_QUES_FALL    = 5'h16,
        OP_QUES_FALL_Q  = 5'h17,
        OP_QUES_RISE    = 5'h18,
        OP_QUES_RISE_Q  = 5'h19
    } spsc_op_e;

    typedef struct packed {
        logic        valid;
        spsc_op_e    op;
        logic [15:0] arg;
    } spsc_cmd_s;

    typedef struct packed {
        logic        valid;
        logic        err;
        logic [15:0] data;
    } spsc_rsp_s;

    // One-cycle trip strobes from the protection circuits
    typedef struct packed {
        logic overVolt;
        logic overCurrExt;
        logic overTemp;
        logic inhibit;
    } spsc_trip_s;

endpackage : spsc_pkg

`default_nettype wire

// ==== spsc_protection_status.sv ====
// Protection clearing, relay control, settle filter and status register groups
`default_nettype none

module spsc_protection_status
    import spsc_pkg::*;
#(
    parameter int SETTLE_UNIT_CYC = DELAY_UNIT_CYC
)
(
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // Command port from the instrument interface
    input  wire spsc_cmd_s     cmd,
    output spsc_rsp_s          rsp,
    // Accessory configuration
    input  wire logic          relayFitted,
    input  wire logic          polarityFitted,
    // Live supply state
    input  wire logic          constVoltageRaw,
    input  wire logic          constCurrentRaw,
    input  wire logic          unregulatedRaw,
    input  wire logic          triggerWait,
    input  wire logic          currentOverLevel,
    input  wire spsc_trip_s    trip,
    // Output control
    output logic               outputDisable,
    output logic               relayClose,
    output logic               relayReverse,
    // Status byte summaries
    output logic               operSummary,
    output logic               quesSummary
);

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    function automatic logic isOp(input spsc_cmd_s c, input spsc_op_e o);
        return c.valid && (c.op == o);
    endfunction

    logic clearCmd;
    logic relayCmd;
    logic polCmd;
    logic relayOk;
    logic polOk;

    assign clearCmd = isOp(cmd, OP_PROT_CLEAR);
    assign relayCmd = isOp(cmd, OP_RELAY_SET);
    assign polCmd   = isOp(cmd, OP_POL_SET);
    assign relayOk  = relayCmd && relayFitted;
    assign polOk    = polCmd && polarityFitted;

    // ------------------------------------------------------------------
    // Programmable values
    // ------------------------------------------------------------------
    logic [15:0] delay_ff;
    logic        ocpEnable_ff;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            delay_ff     <= DELAY_RST;
            ocpEnable_ff <= 1'b0;
        end
        else
        begin
            if (isOp(cmd, OP_DELAY_SET))
            begin
                delay_ff <= cmd.arg;
            end
            if (isOp(cmd, OP_OCP_SET))
            begin
                ocpEnable_ff <= cmd.arg[0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Latched protection conditions
    // ------------------------------------------------------------------
    logic overVolt_ff;
    logic overCurr_ff;
    logic overCurrExt_ff;
    logic overTemp_ff;
    logic inhibit_ff;
    logic overCurrTrip;
    logic anyTrip;

    assign overCurrTrip = ocpEnable_ff && currentOverLevel;
    assign anyTrip      = (|trip) || overCurrTrip;

    // A trip in the clear cycle wins over the clear
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overVolt_ff    <= 1'b0;
            overCurr_ff    <= 1'b0;
            overCurrExt_ff <= 1'b0;
            overTemp_ff    <= 1'b0;
            inhibit_ff     <= 1'b0;
        end
        else
        begin
            overVolt_ff    <= (overVolt_ff && !clearCmd) || trip.overVolt;
            overCurr_ff    <= (overCurr_ff && !clearCmd) || overCurrTrip;
            overTemp_ff    <= (overTemp_ff && !clearCmd) || trip.overTemp;
            inhibit_ff     <= (inhibit_ff && !clearCmd) || trip.inhibit;
            // Externally forced overcurrent is not released by a clear
            overCurrExt_ff <= overCurrExt_ff || trip.overCurrExt;
        end
    end

    logic outDis_ff;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            outDis_ff <= 1'b0;
        end
        else if (anyTrip)
        begin
            outDis_ff <= 1'b1;
        end
        else if (clearCmd && !overCurrExt_ff)
        begin
            outDis_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Relay state and polarity
    // ------------------------------------------------------------------
    logic relay_ff;
    logic relaySaved_ff;
    logic tripped_ff;
    logic reverse_ff;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            relay_ff      <= 1'b0;
            relaySaved_ff <= 1'b0;
            tripped_ff    <= 1'b0;
        end
        else if (anyTrip)
        begin
            // Only the first trip records the state to come back to
            if (!tripped_ff)
            begin
                relaySaved_ff <= relay_ff;
            end
            relay_ff   <= 1'b0;
            tripped_ff <= 1'b1;
        end
        else if (clearCmd && tripped_ff)
        begin
            relay_ff   <= relayFitted ? relaySaved_ff : relay_ff;
            tripped_ff <= 1'b0;
        end
        else if (relayOk)
        begin
            relay_ff <= cmd.arg[0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reverse_ff <= 1'b0;
        end
        else if (polOk)
        begin
            reverse_ff <= cmd.arg[0];
        end
    end

    // ------------------------------------------------------------------
    // Settled regulation modes and condition words
    // ------------------------------------------------------------------
    logic [2:0]  settled;
    logic [15:0] operCond;
    logic [15:0] quesCond;

    spsc_settle_filter #(
        .W        (3),
        .UNIT_CYC (SETTLE_UNIT_CYC)
    ) u_settle (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .rawIn      ({unregulatedRaw, constCurrentRaw, constVoltageRaw}),
        .delayUnits (delay_ff),
        .settled    (settled)
    );

    always_comb
    begin
        operCond               = 16'h0000;
        operCond[OPER_CURR_BIT]  = settled[1];
        operCond[OPER_VOLT_BIT]  = settled[0];
        operCond[OPER_WAIT_BIT]  = triggerWait;
        quesCond                 = 16'h0000;
        quesCond[QUES_VOLT_BIT]  = overVolt_ff;
        quesCond[QUES_CURR_BIT]  = overCurr_ff || overCurrExt_ff;
        quesCond[QUES_TEMP_BIT]  = overTemp_ff;
        quesCond[QUES_INHB_BIT]  = inhibit_ff;
        quesCond[QUES_NOREG_BIT] = settled[2];
    end

    // ------------------------------------------------------------------
    // Status register groups
    // ------------------------------------------------------------------
    logic [15:0] opEnab;
    logic [15:0] opFall;
    logic [15:0] opRise;
    logic [15:0] opEvent;
    logic        opSum;
    logic [15:0] quEnab;
    logic [15:0] quFall;
    logic [15:0] quRise;
    logic [15:0] quEvent;
    logic        quSum;

    spsc_status_group #(
        .USED_MASK (OPER_USED_MASK)
    ) u_oper (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .cond       (operCond),
        .wrEnable   (isOp(cmd, OP_OPER_ENAB)),
        .wrFall     (isOp(cmd, OP_OPER_FALL)),
        .wrRise     (isOp(cmd, OP_OPER_RISE)),
        .wrData     (cmd.arg),
        .rdEvent    (isOp(cmd, OP_OPER_EVEN)),
        .enableMask (opEnab),
        .fallFilter (opFall),
        .riseFilter (opRise),
        .eventLatch (opEvent),
        .summary    (opSum)
    );

    spsc_status_group #(
        .USED_MASK (QUES_USED_MASK)
    ) u_ques (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .cond       (quesCond),
        .wrEnable   (isOp(cmd, OP_QUES_ENAB)),
        .wrFall     (isOp(cmd, OP_QUES_FALL)),
        .wrRise     (isOp(cmd, OP_QUES_RISE)),
        .wrData     (cmd.arg),
        .rdEvent    (isOp(cmd, OP_QUES_EVEN)),
        .enableMask (quEnab),
        .fallFilter (quFall),
        .riseFilter (quRise),
        .eventLatch (quEvent),
        .summary    (quSum)
    );

    // ------------------------------------------------------------------
    // Responses: one cycle after each command
    // ------------------------------------------------------------------
    spsc_rsp_s nxt_rsp;
    spsc_rsp_s rsp_ff;

    always_comb
    begin
        nxt_rsp       = '0;
        nxt_rsp.valid = cmd.valid;
        unique case (cmd.op)
            OP_DELAY_QRY:   nxt_rsp.data = delay_ff;
            OP_DELAY_MIN:   nxt_rsp.data = DELAY_MIN;
            OP_DELAY_MAX:   nxt_rsp.data = DELAY_MAX;
            OP_RELAY_SET:   nxt_rsp.err  = !relayFitted;
            OP_RELAY_QRY:   nxt_rsp.data = {15'h0000, relay_ff};
            OP_POL_SET:     nxt_rsp.err  = !polarityFitted;
            OP_POL_QRY:     nxt_rsp.data = {15'h0000, reverse_ff};
            OP_OPER_COND:   nxt_rsp.data = operCond;
            OP_OPER_ENAB_Q: nxt_rsp.data = opEnab;
            OP_OPER_EVEN:   nxt_rsp.data = opEvent;
            OP_OPER_FALL_Q: nxt_rsp.data = opFall;
            OP_OPER_RISE_Q: nxt_rsp.data = opRise;
            OP_QUES_COND:   nxt_rsp.data = quesCond;
            OP_QUES_ENAB_Q: nxt_rsp.data = quEnab;
            OP_QUES_EVEN:   nxt_rsp.data = quEvent;
            OP_QUES_FALL_Q: nxt_rsp.data = quFall;
            OP_QUES_RISE_Q: nxt_rsp.data = quRise;
            OP_PROT_CLEAR, OP_DELAY_SET, OP_OCP_SET, OP_OPER_ENAB, OP_OPER_FALL,
            OP_OPER_RISE, OP_QUES_ENAB, OP_QUES_FALL, OP_QUES_RISE:
                            nxt_rsp.data = 16'h0000;
            default:        nxt_rsp.err  = cmd.valid;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_ff <= '0;
        end
        else
        begin
            rsp_ff <= nxt_rsp;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    logic outDisQ_ff;
    logic operSum_ff;
    logic quesSum_ff;
    logic relayQ_ff;
    logic reverseQ_ff;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            outDisQ_ff  <= 1'b0;
            operSum_ff  <= 1'b0;
            quesSum_ff  <= 1'b0;
            relayQ_ff   <= 1'b0;
            reverseQ_ff <= 1'b0;
        end
        else
        begin
            outDisQ_ff  <= outDis_ff;
            operSum_ff  <= opSum;
            quesSum_ff  <= quSum;
            relayQ_ff   <= relay_ff;
            reverseQ_ff <= reverse_ff;
        end
    end

    assign rsp           = rsp_ff;
    assign outputDisable = outDisQ_ff;
    assign relayClose    = relayQ_ff;
    assign relayReverse  = reverseQ_ff;
    assign operSummary   = operSum_ff;
    assign quesSummary   = quesSum_ff;

endmodule // spsc_protection_status

`default_nettype wire

// ==== spsc_ps_assertions.sv ====
// Port checker of the protection and status block
`default_nettype none
module spsc_ps_checker
    import spsc_pkg::*;
(
    // Watched ports
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire spsc_cmd_s  cmd,
    input wire spsc_rsp_s  rsp,
    input wire logic       relayFitted,
    input wire logic       polarityFitted,
    input wire spsc_trip_s trip,
    input wire logic       outputDisable,
    input wire logic       relayClose,
    input wire logic       relayReverse
);
    timeunit 1ns/1ps;
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_rsp_follows: assert property (cmd.valid |=> rsp.valid)
        else $error("no response");
    a_rsp_idle: assert property (!cmd.valid |=> !rsp.valid)
        else $error("stray response");
    a_delay_min: assert property (cmd.valid && cmd.op == OP_DELAY_MIN
        |=> rsp.data == DELAY_MIN) else $error("bad min delay");
    a_relay_refuse: assert property (cmd.valid && cmd.op == OP_RELAY_SET
        && !relayFitted |=> rsp.err) else $error("relay not refused");
    a_pol_refuse: assert property (cmd.valid && cmd.op == OP_POL_SET
        && !polarityFitted |=> rsp.err ##1 $stable(relayReverse)) else $error("pol acted");
    a_pol_follow: assert property (cmd.valid && cmd.op == OP_POL_SET
        && polarityFitted |-> ##2 relayReverse == $past(cmd.arg[0], 2)) else $error("pol");
    a_oper_unused: assert property (cmd.valid && cmd.op == OP_OPER_COND
        |=> (rsp.data & ~OPER_USED_MASK) == 16'h0000) else $error("unused bit set");
    a_trip_off: assert property (trip != 4'h0
        |-> ##[1:3] (outputDisable && !relayClose)) else $error("trip ignored");
endmodule // spsc_ps_checker
bind spsc_protection_status spsc_ps_checker chk_u (.sys_clk, .rst_n, .cmd, .rsp,
    .relayFitted, .polarityFitted, .trip, .outputDisable, .relayClose, .relayReverse);
`default_nettype wire

// ==== spsc_settle_filter.sv ====
// Settle-delay filter for regulation-mode flags
`default_nettype none

module spsc_settle_filter
    import spsc_pkg::*;
#(
    parameter int W        = 3,
    parameter int UNIT_CYC = DELAY_UNIT_CYC
)
(
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // Raw flags and programmed delay
    input  wire logic [W-1:0]  rawIn,
    input  wire logic [15:0]   delayUnits,
    // Settled flags
    output logic      [W-1:0]  settled
);

    localparam int PW = (UNIT_CYC > 1) ? $clog2(UNIT_CYC) : 1;

    logic [W-1:0]  pending_ff;
    logic [W-1:0]  settled_ff;
    logic [PW-1:0] prescale_ff;
    logic [15:0]   units_ff;
    logic          changed;
    logic          unitTick;

    assign changed  = (rawIn != pending_ff);
    assign unitTick = (prescale_ff == PW'(UNIT_CYC - 1));
    assign settled  = settled_ff;

    // ------------------------------------------------------------------
    // Persistence timer: any new change restarts the wait
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending_ff  <= '0;
            prescale_ff <= '0;
            units_ff    <= 16'h0000;
        end
        else if (changed)
        begin
            pending_ff  <= rawIn;
            prescale_ff <= '0;
            units_ff    <= 16'h0000;
        end
        else if (pending_ff != settled_ff && units_ff < delayUnits)
        begin
            prescale_ff <= unitTick ? '0 : prescale_ff + PW'(1);
            if (unitTick)
            begin
                units_ff <= units_ff + 16'h0001;
            end
        end
    end

    // Short excursions never reach the output
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            settled_ff <= '0;
        end
        else if (!changed && units_ff >= delayUnits)
        begin
            settled_ff <= pending_ff;
        end
    end

endmodule // spsc_settle_filter

`default_nettype wire

// ==== spsc_status_group.sv ====
// One status register group: condition, enable, event and edge filters
`default_nettype none

module spsc_status_group
    import spsc_pkg::*;
#(
    parameter logic [15:0] USED_MASK = OPER_USED_MASK
)
(
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // Live condition
    input  wire logic [15:0]   cond,
    // Register writes and event read
    input  wire logic          wrEnable,
    input  wire logic          wrFall,
    input  wire logic          wrRise,
    input  wire logic [15:0]   wrData,
    input  wire logic          rdEvent,
    // Register contents
    output logic      [15:0]   enableMask,
    output logic      [15:0]   fallFilter,
    output logic      [15:0]   riseFilter,
    output logic      [15:0]   eventLatch,
    output logic               summary
);

    logic [15:0] enable_ff;
    logic [15:0] fall_ff;
    logic [15:0] rise_ff;
    logic [15:0] event_ff;
    logic [15:0] prevCond_ff;
    logic [15:0] condUsed;
    logic [15:0] setBits;

    assign condUsed   = cond & USED_MASK;
    assign enableMask = enable_ff;
    assign fallFilter = fall_ff;
    assign riseFilter = rise_ff;
    assign eventLatch = event_ff;
    assign summary    = |(event_ff & enable_ff);

    // ------------------------------------------------------------------
    // Event sources: filtered edges, and filter writes over a held level
    // ------------------------------------------------------------------
    always_comb
    begin
        setBits = enable_ff & ((condUsed & ~prevCond_ff & rise_ff)
                             | (~condUsed & prevCond_ff & fall_ff));
        if (wrRise)
        begin
            setBits = setBits | (enable_ff & wrData & ~rise_ff & condUsed);
        end
        if (wrFall)
        begin
            setBits = setBits | (enable_ff & wrData & ~fall_ff & ~condUsed & USED_MASK);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_ff <= ENAB_RST;
            fall_ff   <= FALL_RST;
            rise_ff   <= RISE_RST;
        end
        else
        begin
            if (wrEnable)
            begin
                enable_ff <= wrData;
            end
            if (wrFall)
            begin
                fall_ff <= wrData;
            end
            if (wrRise)
            begin
                rise_ff <= wrData;
            end
        end
    end

    // A set in the read cycle survives the clear
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            event_ff    <= 16'h0000;
            prevCond_ff <= 16'h0000;
        end
        else
        begin
            prevCond_ff <= condUsed;
            event_ff    <= ((rdEvent ? 16'h0000 : event_ff) | setBits) & USED_MASK;
        end
    end

endmodule // spsc_status_group

`default_nettype wire

// ==== tb.sv ====
// Self-checking bench of the protection and status block
`default_nettype none
module tb;
    import spsc_pkg::*;
    timeunit 1ns/1ps;
    logic        sys_clk = 1'b0, rst_n = 1'b0, relFit = 1'b1, polFit = 1'b1, e;
    logic        voltRaw = 1'b0, currRaw = 1'b0, unregRaw = 1'b0;
    logic        trigWait = 1'b0, overLvl = 1'b0;
    logic        relClose, relRev, operSum, outDis, quesSum;
    logic [15:0] d;
    spsc_cmd_s   cmd;
    spsc_rsp_s   rsp;
    spsc_trip_s  trip = '0;
    int          mismatches = 0, cmpCount = 0, cycles = 0;
    spsc_protection_status #(.SETTLE_UNIT_CYC(4)) dut_u (.sys_clk, .rst_n, .cmd, .rsp,
        .relayFitted(relFit), .polarityFitted(polFit), .constVoltageRaw(voltRaw),
        .constCurrentRaw(currRaw), .unregulatedRaw(unregRaw), .triggerWait(trigWait),
        .currentOverLevel(overLvl), .trip, .outputDisable(outDis), .relayClose(relClose),
        .relayReverse(relRev), .operSummary(operSum), .quesSummary(quesSum));
    spsc_ctrl_model ctl_u (.sys_clk, .cmd, .rsp);
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (++cycles == 1000) final_report(1);
    task automatic final_report(input int late);
        mismatches += late;
        if (mismatches == 0 && cmpCount > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] x, g);
        cmpCount++;
        mismatches += int'(x !== g);
        if (x !== g)
            $display("BAD %s expected %h seen %h", n, x, g);
    endtask
    task automatic tx(input spsc_op_e op, input logic [15:0] arg = 16'h0000);
        ctl_u.send(op, arg, d, e);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic t_status();
        tx(OP_DELAY_SET, 16'h0002);
        tx(OP_DELAY_QRY);
        chk("delay", 16'h0002, d);
        tx(OP_DELAY_MIN);
        tx(OP_OPER_ENAB, 16'h0500);
        tx(OP_OPER_RISE, 16'h0500);
        voltRaw = 1'b1;
        step(4);
        voltRaw = 1'b0;
        step(12);
        tx(OP_OPER_EVEN);
        chk("glitch", 16'h0000, d);
        {voltRaw, currRaw, unregRaw} = 3'b111;
        step(14);
        tx(OP_OPER_COND);
        chk("cond", 16'h0500, d);
        chk("sum", 16'h0001, operSum);
        tx(OP_QUES_COND);
        chk("unregulated_flag", 16'h0400, d);
        tx(OP_OPER_EVEN);
        chk("event", 16'h0500, d);
        {voltRaw, currRaw, unregRaw} = 3'b000;
        step(14);
        tx(OP_OPER_EVEN);
        chk("fall", 16'h0000, d);
        tx(OP_OPER_FALL, 16'h0100);
        tx(OP_OPER_EVEN);
        chk("fallWrite", 16'h0100, d);
        voltRaw = 1'b1;
        step(14);
        tx(OP_OPER_EVEN);
        chk("rise", 16'h0100, d);
        voltRaw = 1'b0;
        step(14);
        tx(OP_OPER_EVEN);
        chk("fallEdge", 16'h0100, d);
        trigWait = 1'b1;
        tx(OP_OPER_COND);
        chk("wait", 16'h0020, d);
        trigWait = 1'b0;
    endtask
    task automatic t_relay();
        tx(OP_RELAY_SET, 16'h0001);
        step(1);
        chk("close", 16'h0001, relClose);
        trip.overVolt = 1'b1;
        step(1);
        trip.overVolt = 1'b0;
        step(3);
        tx(OP_QUES_COND);
        chk("voltSet", 16'h0001, d);
        tx(OP_PROT_CLEAR);
        step(1);
        chk("restore", 16'h0001, relClose);
        tx(OP_QUES_COND);
        chk("voltClear", 16'h0000, d);
        relFit = 1'b0;
        tx(OP_RELAY_SET);
        chk("refused", 16'h0001, e);
    endtask
    task automatic t_pol();
        tx(OP_POL_SET, 16'h0001);
        step(1);
        chk("reverse", 16'h0001, relRev);
        polFit = 1'b0;
        tx(OP_POL_SET);
        chk("polErr", 16'h0001, e);
    endtask
    task automatic t_ocp();
        tx(OP_QUES_ENAB, 16'h0002);
        tx(OP_QUES_RISE, 16'h0002);
        tx(OP_OCP_SET, 16'h0001);
        overLvl = 1'b1;
        step(1);
        overLvl = 1'b0;
        step(2);
        chk("ocpOff", 16'h0001, outDis);
        chk("quesSum", 16'h0001, quesSum);
        tx(OP_QUES_COND);
        chk("currFlag", 16'h0002, d);
        tx(OP_PROT_CLEAR);
        step(1);
        chk("currClear", 16'h0000, outDis);
    endtask
    initial
    begin
        step(6);
        rst_n = 1'b1;
        t_status();
        t_relay();
        t_pol();
        t_ocp();
        final_report(0);
    end
endmodule // tb
`default_nettype wire
